// ===== rtl/lps_cfg.svh
// Constants of the latched parallel-in serial-out shift register
`ifndef LPS_CFG_SVH
`define LPS_CFG_SVH
`define LPS_STAGES      8
`define LPS_STAGE_RST   8'h00
`define LPS_LAST_STAGE  7
`define LPS_FIFO_DEPTH  2
`define LPS_FIFO_WIDTH  1
`define LPS_BIT_ZERO    1'b0
`define LPS_BIT_ONE     1'b1
`endif

// ===== rtl/lps_pkg.sv
// Types of the latched parallel-in serial-out shift register
`include "lps_cfg.svh"
package lps_pkg;
   typedef logic [`LPS_STAGES-1:0] lps_word_t;
   // One-hot operating mode of the shift register
   typedef enum logic [1:0] {
      LPS_LOAD  = 2'h1,
      LPS_SHIFT = 2'h2
   } lps_mode_t;
endpackage

// ===== rtl/lps_shift_reg.sv
// Latched parallel-in serial-out shift register with output buffer
// Notes on behaviour
// - Latch clock rise captures parallel inputs; latch holds otherwise.
// - Mode high: shift clock rising edge moves serial input into stage one, unless the buffer is full.
// - Mode low: serial input never reaches any stage.
// - Mode high permits serial shifting on shift clock edges.
// - Mode low loads latch contents into all stages; shifting inhibited.
// - Reset low clears all stages at once, without a clock.
// - Reset leaves the input latch untouched.
// - Each shift moves every stage one place toward the output.
// - Serial output always shows the last stage.
`timescale 1ns/1ps
`include "lps_cfg.svh"
module lps_shift_reg
   import lps_pkg::*;
#(
   parameter int DEPTH = `LPS_FIFO_DEPTH,
   parameter int WIDTH = `LPS_FIFO_WIDTH
) (
   input  wire logic             sys_clk_i,
   input  wire logic             resetn_i,
   input  wire logic [`LPS_STAGES-1:0] par_data_i,
   input  wire logic             latch_clk_i,
   input  wire logic             shift_clk_i,
   input  wire logic             shift_mode_i,
   input  wire logic             ser_data_i,
   input  wire logic             out_ready_i,
   output logic                  ser_q_o,
   output logic                  shift_ready_o,
   output logic                  out_valid_o,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointer step with wrap, used by both buffer ends
   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      if (p == PW'(DEPTH - 1)) begin
         ptr_inc = '0;
      end else begin
         ptr_inc = p + PW'(1);
      end
   endfunction

   // ------------------------------------------------------------
   // Input latch
   // ------------------------------------------------------------
   lps_word_t latch_r;
   lps_word_t latch_nxt;
   logic      lclk_q_r;
   logic      lclk_rise;

   // Latch and its edge detector carry no reset: reset must not touch it
   always_comb begin
      lclk_rise = latch_clk_i & ~lclk_q_r;
      latch_nxt = lclk_rise ? par_data_i : latch_r;
   end

   always_ff @(posedge sys_clk_i) begin
      lclk_q_r <= latch_clk_i;
      latch_r  <= latch_nxt;
   end

   // ------------------------------------------------------------
   // Shift register stages
   // ------------------------------------------------------------
   lps_word_t stage_r;
   lps_word_t stage_nxt;
   logic      sclk_q_r;
   logic      sclk_rise;
   logic      shift_go;
   logic      full;
   lps_mode_t mode;

   // Load follows latch as a level; a shift edge is ignored while the buffer is full
   always_comb begin
      mode      = shift_mode_i ? LPS_SHIFT : LPS_LOAD;
      sclk_rise = shift_clk_i & ~sclk_q_r;
      shift_go  = 1'b0;
      stage_nxt = stage_r;
      case (mode)
         LPS_LOAD: begin
            stage_nxt = latch_r;
         end
         LPS_SHIFT: begin
            if (sclk_rise && !full) begin
               shift_go  = 1'b1;
               // Bit 0 is stage A, bit 7 stage H at the output
               stage_nxt = {stage_r[`LPS_LAST_STAGE-1:0],
                            ser_data_i};
            end
         end
         default: begin
            stage_nxt = stage_r;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage_r  <= `LPS_STAGE_RST;
         sclk_q_r <= `LPS_BIT_ONE;
      end else begin
         stage_r  <= stage_nxt;
         sclk_q_r <= shift_clk_i;
      end
   end

   // Output pin is the last stage flop itself
   assign ser_q_o = stage_r[`LPS_LAST_STAGE];

   // ------------------------------------------------------------
   // Buffer of shifted-out bits
   // ------------------------------------------------------------
   logic [WIDTH-1:0] mem_r   [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [PW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
   logic [PW:0]      cnt_r, cnt_nxt;
   logic             push, pop;
   logic             valid_nxt, ready_nxt;
   logic [WIDTH-1:0] data_nxt;

   // A full buffer stalls shifting so no outgoing bit is lost
   always_comb begin
      full   = (cnt_r == (PW+1)'(DEPTH));
      push   = shift_go;
      pop    = out_ready_i && (cnt_r != '0);
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      for (int i = 0; i < DEPTH; i++) begin
         mem_nxt[i] = mem_r[i];
      end
      if (push) begin
         mem_nxt[wr_r] = WIDTH'(stage_r[`LPS_LAST_STAGE]);
         wr_nxt        = ptr_inc(wr_r);
      end
      if (pop) begin
         rd_nxt = ptr_inc(rd_r);
      end
      cnt_nxt   = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      valid_nxt = (cnt_nxt != '0);
      ready_nxt = (cnt_nxt != (PW+1)'(DEPTH));
      data_nxt  = mem_nxt[rd_nxt];
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
         wr_r          <= '0;
         rd_r          <= '0;
         cnt_r         <= '0;
         out_valid_o   <= `LPS_BIT_ZERO;
         shift_ready_o <= `LPS_BIT_ZERO;
         out_data_o    <= '0;
      end else begin
         mem_r         <= mem_nxt;
         wr_r          <= wr_nxt;
         rd_r          <= rd_nxt;
         cnt_r         <= cnt_nxt;
         out_valid_o   <= valid_nxt;
         shift_ready_o <= ready_nxt;
         out_data_o    <= data_nxt;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   latch_capture_a: assert property (@(posedge sys_clk_i)
      lclk_rise |=> latch_r == $past(par_data_i))
      else $error("latch missed parallel data");

   latch_hold_a: assert property (@(posedge sys_clk_i)
      !lclk_rise |=> $stable(latch_r))
      else $error("latch changed without edge");

   shift_in_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      shift_mode_i && sclk_rise && !full |=> stage_r[0] == $past(ser_data_i))
      else $error("serial bit not in first stage");

   stage_move_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      shift_go |=> stage_r[`LPS_LAST_STAGE:1] ==
                   $past(stage_r[`LPS_LAST_STAGE-1:0]))
      else $error("stages did not advance");

   load_mode_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      !shift_mode_i |=> stage_r == $past(latch_r))
      else $error("load mode did not copy latch");

   no_shift_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      shift_mode_i && !shift_go |=> $stable(stage_r))
      else $error("stages moved without shift");

   reset_clear_a: assert property (@(posedge sys_clk_i)
      !resetn_i |-> stage_r == `LPS_STAGE_RST && !ser_q_o)
      else $error("reset did not clear stages");

   out_track_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      shift_go |=> ser_q_o == $past(stage_r[`LPS_LAST_STAGE-1]))
      else $error("output not last stage");

   stall_full_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      full && !pop |=> $stable(stage_r) || !$past(shift_mode_i))
      else $error("shift while buffer full");

   // Ready must never promise room that the buffer lacks
   ready_room_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      shift_ready_o |-> !full)
      else $error("ready shown while buffer full");

   // Every bit that leaves the last stage shows up at the drain side
   push_valid_a: assert property (@(posedge sys_clk_i)
      disable iff (!resetn_i)
      shift_go |=> out_valid_o)
      else $error("shifted bit not offered");

endmodule // lps_shift_reg

// ===== bench/lps_host.sv
// Host controller model driving the control pins of the shift register
`timescale 1ns/1ps
module lps_host (
   input  wire logic  sys_clk_i,
   input  wire logic  shift_ready_i,
   output logic [7:0] par_data_o,
   output logic       latch_clk_o,
   output logic       shift_clk_o,
   output logic       shift_mode_o,
   output logic       ser_data_o
);
   // Idle: clocks low, mode high
   initial begin
      par_data_o = 8'h00;
      latch_clk_o = 1'b0;
      shift_clk_o = 1'b0;
      shift_mode_o = 1'b1;
      ser_data_o = 1'b0;
   end
   // Latch pulse; data inverted after so a late sample shows up
   task automatic latch_word(input logic [7:0] w);
      @(negedge sys_clk_i) par_data_o = w;
      latch_clk_o = 1'b1;
      @(negedge sys_clk_i) latch_clk_o = 1'b0;
      par_data_o = ~w;
   endtask
   // Mode low for two cycles while serial input toggles
   task automatic load();
      @(negedge sys_clk_i) shift_mode_o = 1'b0;
      repeat (2) @(negedge sys_clk_i) ser_data_o = ~ser_data_o;
      shift_mode_o = 1'b1;
   endtask
   // One shift edge, once the buffer has room or after at most 50 cycles of waiting
   task automatic shift_bit(input logic b);
      @(negedge sys_clk_i);
      for (int t = 0; t < 50 && shift_ready_i !== 1'b1; t++)
         @(negedge sys_clk_i);
      shift_clk_o = 1'b1;
      ser_data_o = b;
      @(negedge sys_clk_i) shift_clk_o = 1'b0;
      ser_data_o = ~b;
   endtask
endmodule // lps_host

// ===== bench/latched_piso_shift_register_tb.sv
// Self-checking bench for the latched serial shift register
`timescale 1ns/1ps
module latched_piso_shift_register_tb;
   import lps_pkg::*;
   logic sys_clk_i, resetn_i, out_ready_i, ser_q_o, shift_ready_o;
   logic out_valid_o, latch_clk, shift_clk, shift_mode, ser_data;
   logic [0:0] out_data_o;
   logic [7:0] par_data;
   logic       stall;
   int failures, cmp_count, cycles;
   integer seed = 32'hD3EC33F6;
   logic exp_q[$];
   lps_word_t w, s;
   lps_shift_reg u_lps_shift_reg (.sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i), .par_data_i(par_data), .latch_clk_i(latch_clk),
      .shift_clk_i(shift_clk), .shift_mode_i(shift_mode),
      .ser_data_i(ser_data), .out_ready_i(out_ready_i), .ser_q_o(ser_q_o),
      .shift_ready_o(shift_ready_o), .out_valid_o(out_valid_o),
      .out_data_o(out_data_o));
   lps_host u_lps_host (.sys_clk_i(sys_clk_i), .shift_ready_i(shift_ready_o),
      .par_data_o(par_data), .latch_clk_o(latch_clk),
      .shift_clk_o(shift_clk), .shift_mode_o(shift_mode),
      .ser_data_o(ser_data));
   // ----------------------------------------
   // Clock, random drain stall, timeout
   // ----------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // Drain ready is random; stall forces it low to fill the buffer
   always @(negedge sys_clk_i)
      out_ready_i <= stall ? 1'b0 : 1'($random(seed));
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end
   task automatic check(input lps_word_t got, input lps_word_t exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("failures %0d cmp_count %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Oldest noted bit against each popped buffer word
   always @(posedge sys_clk_i)
      if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
         if (exp_q.size() == 0) check(out_data_o, 8'hFF);
         else check(out_data_o, exp_q.pop_front());
      end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      resetn_i = 1'b0;
      stall = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      for (int k = 0; k < 8; k++) begin
         w = $random(seed);
         s = $random(seed);
         s[0] = 1'b1;
         u_lps_host.latch_word(w);
         u_lps_host.load();
         check(ser_q_o, w[7]);
         for (int i = 7; i >= 0; i--) exp_q.push_back(w[i]);
         for (int i = 0; i < 8; i++) u_lps_host.shift_bit(s[i]);
         @(negedge sys_clk_i) check(ser_q_o, s[0]);
         for (int t = 0; t < 100 && exp_q.size() != 0; t++)
            @(negedge sys_clk_i);
      end
      // Reset mid-run clears stages at once, keeps the latch
      @(negedge sys_clk_i) resetn_i = 1'b0;
      stall = 1'b1;
      #1 check(ser_q_o, 1'b0);
      @(negedge sys_clk_i) resetn_i = 1'b1;
      u_lps_host.load();
      check(ser_q_o, w[7]);
      // Whole old word must come out again; drain held off to fill buffer
      for (int i = 7; i >= 0; i--) exp_q.push_back(w[i]);
      u_lps_host.shift_bit(s[0]);
      u_lps_host.shift_bit(s[1]);
      check(shift_ready_o, 1'b0);
      check(out_valid_o, 1'b1);
      stall = 1'b0;
      for (int i = 2; i < 8; i++) u_lps_host.shift_bit(s[i]);
      for (int t = 0; t < 100 && exp_q.size() != 0; t++)
         @(negedge sys_clk_i);
      check(lps_word_t'(exp_q.size()), 8'h00);
      end_sim();
   end
endmodule // latched_piso_shift_register_tb
